/* inc/asp_pkg.sv */
// package for the asynchronous 8k x 8 memory port controller
// holds pin bundles, speed-grade timing and the cycle rounding helpers;
// assumes a single 25 MHz system clock on the controller side
package asp_pkg;

    // ****************************************
    // geometry
    // ****************************************
    localparam int ADDR_W       = 13;
    localparam int DATA_W       = 8;
    localparam int SYNC_STAGES  = 2;
    localparam int CNT_W        = 4;

    // ****************************************
    // timing, ns, indexed by speed grade 0..3
    // ****************************************
    localparam int CLK_NS       = 40;
    localparam int NUM_GRADES   = 4;
    localparam int RC_NS [NUM_GRADES] = '{70, 85, 100, 120};
    localparam int ACC_NS[NUM_GRADES] = '{70, 85, 100, 120};
    localparam int AW_NS [NUM_GRADES] = '{60, 60, 75, 85};
    localparam int WP_NS [NUM_GRADES] = '{50, 50, 60, 70};
    localparam int DS_NS [NUM_GRADES] = '{30, 30, 35, 40};

    // least times round up, never below one cycle
    function automatic int cyc_ceil(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int max2(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    // ****************************************
    // bundles
    // ****************************************
    typedef struct packed {
        logic [ADDR_W-1:0] address_lines;
        logic              select_low_active_n;
        logic              select_high_active;
        logic              oe_n;
        logic              we_n;
        logic [DATA_W-1:0] data_out;
        logic              data_oe;
    } asp_pins_s;

    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } asp_req_s;

    localparam asp_pins_s PINS_IDLE = '{
        address_lines       : '0,
        select_low_active_n : 1'b1,
        select_high_active  : 1'b0,
        oe_n                : 1'b1,
        we_n                : 1'b1,
        data_out            : '0,
        data_oe             : 1'b0
    };

endpackage

/* verilog/asp_sync.sv */
// two-stage synchroniser for the shared data lines coming back in
// assumes the pin level may change at any time relative to clk
`timescale 1ns/10ps
`default_nettype none
module asp_sync
#(
    parameter int WIDTH = 8
)
(
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] q_reg;
    logic [WIDTH-1:0] q_next;

    // first stage feeds only the second stage
    always_comb
    begin
        meta_next = d;
        q_next    = meta_reg;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            meta_reg <= '0;
            q_reg    <= '0;
        end
        else
        begin
            meta_reg <= meta_next;
            q_reg    <= q_next;
        end
    end

    assign q = q_reg;

endmodule
`default_nettype wire

/* verilog/asp_host_ctrl.sv */
// host-side controller for an asynchronous static 8192 x 8 memory
// assumes pins go straight to the memory; read data are resynchronised
// Functional notes
// - write is overlap of selects and strobe
// - selects may also open the write window
// - never drive data while memory drives
// - address held through write window minimum
// - address may change right at select release
// - deselect before supply drops for retention
// - stay deselected one read cycle after retention
`timescale 1ns/10ps
`default_nettype none
module asp_host_ctrl
#(
    parameter int GRADE = 0
)
(
    input  wire logic                             clk,
    input  wire logic                             reset,
    input  wire logic                             req_valid,
    output logic                                  req_ready,
    input  wire asp_pkg::asp_req_s                req,
    output logic                                  rsp_valid,
    output logic      [asp_pkg::DATA_W-1:0]       rsp_rdata,
    input  wire logic                             retain_req,
    output logic                                  retain_ready,
    output asp_pkg::asp_pins_s                    pins,
    input  wire logic [asp_pkg::DATA_W-1:0]       shared_data_lines_in
);

    // ****************************************
    // derived cycle counts
    // ****************************************
    localparam int RC_CYC = asp_pkg::cyc_ceil(asp_pkg::RC_NS[GRADE]);
    localparam int WE_CYC = asp_pkg::max2(
        asp_pkg::max2(asp_pkg::cyc_ceil(asp_pkg::AW_NS[GRADE]),
                      asp_pkg::cyc_ceil(asp_pkg::WP_NS[GRADE])),
        asp_pkg::max2(asp_pkg::cyc_ceil(asp_pkg::DS_NS[GRADE]), RC_CYC));
    // extra cycle covers the edge on which the synchroniser samples
    localparam int RD_CYC = asp_pkg::max2(
        asp_pkg::cyc_ceil(asp_pkg::ACC_NS[GRADE]) + asp_pkg::SYNC_STAGES + 1,
        RC_CYC);
    localparam int CNT_W  = asp_pkg::CNT_W;
    localparam logic [CNT_W-1:0] CNT_MAX = '1;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WRITE,
        ST_READ,
        ST_RECOVER,
        ST_RETAIN,
        ST_WAKE
    } asp_state_e;

    // ****************************************
    // state
    // ****************************************
    asp_state_e                   state_reg;
    asp_state_e                   state_next;
    logic [CNT_W-1:0]             cnt_reg;
    logic [CNT_W-1:0]             cnt_next;
    asp_pkg::asp_pins_s           pins_reg;
    asp_pkg::asp_pins_s           pins_next;
    logic                         rsp_valid_reg;
    logic                         rsp_valid_next;
    logic [asp_pkg::DATA_W-1:0]   rdata_reg;
    logic [asp_pkg::DATA_W-1:0]   rdata_next;
    logic [asp_pkg::DATA_W-1:0]   data_sync;

    asp_sync
    #(
        .WIDTH (asp_pkg::DATA_W)
    )
    u_data_sync
    (
        .clk   (clk),
        .reset (reset),
        .d     (shared_data_lines_in),
        .q     (data_sync)
    );

    // retention request is taken only between accesses
    assign req_ready = (state_reg == ST_IDLE) && !retain_req;

    always_comb
    begin
        state_next     = state_reg;
        cnt_next       = cnt_reg;
        pins_next      = pins_reg;
        rsp_valid_next = 1'b0;
        rdata_next     = rdata_reg;
        unique case (state_reg)
            ST_IDLE:
            begin
                if (retain_req)
                begin
                    state_next = ST_RETAIN;
                end
                else if (req_valid)
                begin
                    pins_next.address_lines       = req.addr;
                    pins_next.select_low_active_n = 1'b0;
                    pins_next.select_high_active  = 1'b1;
                    if (req.write)
                    begin
                        // enable stays high so the memory keeps off the bus
                        pins_next.oe_n     = 1'b1;
                        pins_next.we_n     = 1'b0;
                        pins_next.data_out = req.wdata;
                        pins_next.data_oe  = 1'b1;
                        cnt_next   = CNT_W'(WE_CYC - 1);
                        state_next = ST_WRITE;
                    end
                    else
                    begin
                        pins_next.oe_n    = 1'b0;
                        pins_next.we_n    = 1'b1;
                        pins_next.data_oe = 1'b0;
                        cnt_next   = CNT_W'(RD_CYC - 1);
                        state_next = ST_READ;
                    end
                end
            end
            ST_WRITE, ST_READ:
            begin
                if (cnt_reg == '0)
                begin
                    // strobe and selects drop together; address stays
                    pins_next.select_low_active_n = 1'b1;
                    pins_next.select_high_active  = 1'b0;
                    pins_next.we_n                = 1'b1;
                    pins_next.oe_n                = 1'b1;
                    pins_next.data_oe             = 1'b0;
                    if (state_reg == ST_READ)
                    begin
                        rdata_next     = data_sync;
                        rsp_valid_next = 1'b1;
                    end
                    state_next = ST_RECOVER;
                end
                else
                begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            ST_RECOVER:
            begin
                // one dead cycle lets the memory float its outputs
                state_next = ST_IDLE;
            end
            ST_RETAIN:
            begin
                if (!retain_req)
                begin
                    cnt_next   = CNT_W'(RC_CYC - 1);
                    state_next = ST_WAKE;
                end
            end
            ST_WAKE:
            begin
                if (cnt_reg == '0)
                begin
                    state_next = ST_IDLE;
                end
                else
                begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_reg     <= ST_IDLE;
            cnt_reg       <= '0;
            pins_reg      <= asp_pkg::PINS_IDLE;
            rsp_valid_reg <= 1'b0;
            rdata_reg     <= '0;
        end
        else
        begin
            state_reg     <= state_next;
            cnt_reg       <= cnt_next;
            pins_reg      <= pins_next;
            rsp_valid_reg <= rsp_valid_next;
            rdata_reg     <= rdata_next;
        end
    end

    assign pins         = pins_reg;
    assign rsp_valid    = rsp_valid_reg;
    assign rsp_rdata    = rdata_reg;
    // pins are already deselected whenever this state is reached
    assign retain_ready = (state_reg == ST_RETAIN);

    // ****************************************
    // checks
    // ****************************************
    localparam logic [CNT_W-1:0] RC_LIM = CNT_W'(RC_CYC);
    localparam logic [CNT_W-1:0] WE_LIM = CNT_W'(WE_CYC);

    logic             selected;
    logic [CNT_W-1:0] sel_len_reg;
    logic [CNT_W-1:0] sel_len_next;
    logic [CNT_W-1:0] we_len_reg;
    logic [CNT_W-1:0] we_len_next;
    logic [CNT_W-1:0] wake_run_reg;
    logic [CNT_W-1:0] wake_run_next;

    assign selected = !pins_reg.select_low_active_n
                   && pins_reg.select_high_active;

    always_comb
    begin
        sel_len_next  = selected ? sel_len_reg + 1'b1 : '0;
        we_len_next   = !pins_reg.we_n ? we_len_reg + 1'b1 : '0;
        wake_run_next = retain_ready ? '0
                      : (wake_run_reg == CNT_MAX) ? CNT_MAX
                      : wake_run_reg + 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            sel_len_reg  <= '0;
            we_len_reg   <= '0;
            wake_run_reg <= CNT_MAX;
        end
        else
        begin
            sel_len_reg  <= sel_len_next;
            we_len_reg   <= we_len_next;
            wake_run_reg <= wake_run_next;
        end
    end

    sequence s_write_end;
        $rose(pins_reg.we_n);
    endsequence

    property p_no_contention;
        @(posedge clk) disable iff (reset)
        pins_reg.data_oe |-> pins_reg.oe_n && !pins_reg.we_n;
    endproperty
    a_no_contention: assert property (p_no_contention)
        else $error("data driven while memory output enabled");

    property p_write_window;
        @(posedge clk) disable iff (reset)
        s_write_end |-> we_len_reg >= WE_LIM;
    endproperty
    a_write_window: assert property (p_write_window)
        else $error("write window shorter than minimum");

    property p_write_addr_hold;
        @(posedge clk) disable iff (reset)
        !pins_reg.we_n ##1 1'b1 |-> $stable(pins_reg.address_lines);
    endproperty
    a_write_addr_hold: assert property (p_write_addr_hold)
        else $error("address moved inside write window");

    property p_write_release;
        @(posedge clk) disable iff (reset)
        s_write_end |-> pins_reg.select_low_active_n
                     && !pins_reg.select_high_active
                     && $stable(pins_reg.address_lines);
    endproperty
    a_write_release: assert property (p_write_release)
        else $error("write end without select release");

    property p_retain_desel;
        @(posedge clk) disable iff (reset)
        retain_ready |-> pins_reg.select_low_active_n
                      && !pins_reg.select_high_active;
    endproperty
    a_retain_desel: assert property (p_retain_desel)
        else $error("selected during retention");

    property p_wake_gap;
        @(posedge clk) disable iff (reset)
        $fell(pins_reg.select_low_active_n) |-> wake_run_reg >= RC_LIM;
    endproperty
    a_wake_gap: assert property (p_wake_gap)
        else $error("access too soon after retention");

    property p_access_spacing;
        @(posedge clk) disable iff (reset)
        $rose(pins_reg.select_low_active_n)
            |-> sel_len_reg >= RC_LIM ##1 pins_reg.select_low_active_n;
    endproperty
    a_access_spacing: assert property (p_access_spacing)
        else $error("access shorter than cycle time");

    property p_read_hold;
        @(posedge clk) disable iff (reset)
        !pins_reg.oe_n ##1 1'b1 |-> $stable(pins_reg.address_lines);
    endproperty
    a_read_hold: assert property (p_read_hold)
        else $error("address moved during read");

endmodule
`default_nettype wire

/* sim/asp_sram_model.sv */
// behavioural model of the static 8192 x 8 memory seen at its pins
// assumes the bench resolves the shared data wire from both enables
`timescale 1ns/10ps
`default_nettype none
module asp_sram_model
#(
    parameter int ACC_CYC = 2
)
(
    input  wire logic                       clk,
    input  wire logic [asp_pkg::ADDR_W-1:0] address_lines,
    input  wire logic                       select_low_active_n,
    input  wire logic                       select_high_active,
    input  wire logic                       oe_n,
    input  wire logic                       we_n,
    input  wire logic [asp_pkg::DATA_W-1:0] data_in,
    output logic      [asp_pkg::DATA_W-1:0] data_out,
    output logic                            data_oe
);
    // ****************************************
    // storage and access
    // ****************************************
    logic [asp_pkg::DATA_W-1:0] mem [8192];
    logic [asp_pkg::ADDR_W-1:0] last_addr;
    logic                       sel;
    logic                       wr;
    int                         age;

    assign sel = !select_low_active_n && select_high_active;
    assign wr  = sel && !we_n;

    // write sampled on clk: the window spans whole cycles of the host
    always @(posedge clk)
    begin
        if (wr)
            mem[address_lines] <= data_in;
        // pins move just after an edge, so a fresh address has aged a cycle
        if (!sel)
            age <= 0;
        else if (address_lines != last_addr)
            age <= 1;
        else if (age < ACC_CYC)
            age <= age + 1;
        last_addr <= address_lines;
    end

    // released at once, so the strobe release is well inside its limit
    assign data_oe  = sel && we_n && !oe_n;
    // before access time the outputs show a wrong byte, not the stored one
    assign data_out = (age >= ACC_CYC) ? mem[address_lines]
                                       : ~mem[address_lines];
endmodule
`default_nettype wire

/* sim/async_sram_8k_x8_port_tb_top.sv */
// self-checking bench for the host controller of the 8k x 8 memory
// assumes asp_pkg and asp_host_ctrl are compiled first, grade 0
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) \
    begin \
        compares = compares + 1; \
        if ((g) !== (e)) \
        begin \
            error_cnt = error_cnt + 1; \
            $display("[ERR] %s exp %0h got %0h", nm, e, g); \
        end \
    end
module async_sram_8k_x8_port_tb_top;
    logic                       clk;
    logic                       reset;
    logic                       req_valid;
    logic                       req_ready;
    asp_pkg::asp_req_s          req;
    logic                       rsp_valid;
    logic [7:0]                 rsp_rdata;
    logic                       retain_req;
    logic                       retain_ready;
    asp_pkg::asp_pins_s         pins;
    logic [7:0]                 wire_lvl;
    logic [7:0]                 m_out;
    logic                       m_oe;
    logic [7:0]                 float_pat;
    logic [12:0]                last_addr;
    logic                       sel_now;
    int                         acc_cnt;
    int                         error_cnt;
    int                         compares;

    asp_host_ctrl #(.GRADE(0)) dut (.clk(clk), .reset(reset),
        .req_valid(req_valid), .req_ready(req_ready), .req(req),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .retain_req(retain_req), .retain_ready(retain_ready),
        .pins(pins), .shared_data_lines_in(wire_lvl));
    asp_sram_model u_mem (.clk(clk), .address_lines(pins.address_lines),
        .select_low_active_n(pins.select_low_active_n),
        .select_high_active(pins.select_high_active), .oe_n(pins.oe_n),
        .we_n(pins.we_n), .data_in(wire_lvl), .data_out(m_out),
        .data_oe(m_oe));

    // an undriven wire changes every cycle so stale data cannot pass
    assign wire_lvl = pins.data_oe ? pins.data_out : (m_oe ? m_out : float_pat);
    assign sel_now  = !pins.select_low_active_n && pins.select_high_active;

    // ****************************************
    // clock and pin watch
    // ****************************************
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk)
    begin
        float_pat <= float_pat + 8'h3b;
        if (!reset)
            `CHK("bus clash", 1'b0, pins.data_oe && m_oe)
        if (sel_now && acc_cnt != 0)
            `CHK("address held", last_addr, pins.address_lines)
        if (!sel_now && acc_cnt != 0)
            `CHK("window cycles", 1'b1, acc_cnt >= 2)
        acc_cnt   <= (sel_now && !reset) ? acc_cnt + 1 : 0;
        last_addr <= pins.address_lines;
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic do_req(input logic w, input logic [12:0] a,
                          input logic [7:0] d);
        logic took;
        took = 1'b0;
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{write: w, addr: a, wdata: d};
        for (int i = 0; i < 50 && !took; i++)
        begin
            @(negedge clk);
            took = (req_ready === 1'b1);
            @(posedge clk);
        end
        req_valid <= 1'b0;
        `CHK("request taken", 1'b1, took)
    endtask

    task automatic wait_rsp(input logic [7:0] e);
        int n;
        n = 0;
        for (int i = 1; i < 20 && n == 0; i++)
        begin
            @(posedge clk);
            #1;
            if (rsp_valid === 1'b1)
                n = i;
        end
        `CHK("read latency", 5, n)
        `CHK("read data", e, rsp_rdata)
        @(posedge clk);
    endtask

    task automatic do_reset();
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        #1;
        `CHK("idle pins", asp_pkg::PINS_IDLE, pins)
        `CHK("ready at reset", 1'b1, req_ready)
        `CHK("retain at reset", 1'b0, retain_ready)
        @(posedge clk);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_fill_read();
        logic [12:0] a [4];
        logic [7:0]  d [4];
        a = '{13'h0000, 13'h1fff, 13'h0aaa, 13'h1555};
        d = '{8'h5a, 8'ha5, 8'hff, 8'h00};
        for (int i = 0; i < 4; i++)
            do_req(1'b1, a[i], d[i]);
        for (int i = 3; i >= 0; i--)
        begin
            do_req(1'b0, a[i], 8'h00);
            wait_rsp(d[i]);
        end
    endtask

    task automatic t_rewrite();
        do_req(1'b1, 13'h1fff, 8'h3c);
        do_req(1'b0, 13'h1fff, 8'h00);
        wait_rsp(8'h3c);
        do_req(1'b0, 13'h0000, 8'h00);
        wait_rsp(8'h5a);
    endtask

    task automatic t_retain_mid_read();
        int n;
        n = 0;
        do_req(1'b0, 13'h1555, 8'h00);
        retain_req <= 1'b1;
        wait_rsp(8'h00);
        repeat (4) @(posedge clk);
        #1;
        `CHK("retain ready", 1'b1, retain_ready)
        `CHK("deselected", 1'b1, !sel_now)
        `CHK("no take in retain", 1'b0, req_ready)
        @(posedge clk);
        retain_req <= 1'b0;
        for (int i = 1; i < 20 && n == 0; i++)
        begin
            @(posedge clk);
            #1;
            `CHK("wake deselected", 1'b1, !sel_now)
            if (req_ready === 1'b1)
                n = i;
        end
        `CHK("wake cycles", (70 + 39) / 40 + 1, n)
        @(posedge clk);
        do_req(1'b0, 13'h1fff, 8'h00);
        wait_rsp(8'h3c);
    endtask

    task automatic close_out();
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        req_valid  = 1'b0;
        req        = '0;
        retain_req = 1'b0;
        float_pat  = 8'h00;
        acc_cnt    = 0;
        error_cnt  = 0;
        compares   = 0;
        do_reset();
        t_fill_read();
        t_rewrite();
        t_retain_mid_read();
        // controller reset mid-run must not disturb what the memory holds
        do_reset();
        do_req(1'b0, 13'h0aaa, 8'h00);
        wait_rsp(8'hff);
        close_out();
    end

    // the scenarios need well under a thousand cycles
    initial
    begin
        #(40 * 20000);
        error_cnt = error_cnt + 1;
        close_out();
    end
endmodule
`default_nettype wire
